// *** rtl/debug_entry_cfg.svh ***
// Constants for the debug entry and return-address tracking logic.
// Assumes inclusion by the package and the design modules only.
// Operation
// - Watchpoint entry adds four, one per instruction
// - Watchpoint with abort waits for abort vector
// - Exception during watchpoint sets exception mode, or interrupt mode if one is pending
// - Watchpoint entry with exception adds three, not four
// - External request entry adds three, one per instruction
// - Each system-speed access adds three addresses
// - Aborted system access enters abort mode first
// - Cause shown by break flag, method bit
// - Prefetch abort beats breakpoint, breakpoint ignored
// - Interrupts disabled on every debug entry
// - Pending interrupt gives interrupt mode, remembered, except on watchpointed data abort
// - Watchpointed data abort gives abort mode, remembered
// - Breakpoint entry adds four, one per instruction
`ifndef DEBUG_ENTRY_CFG_SVH
`define DEBUG_ENTRY_CFG_SVH

// ==========================================================
// Program counter advance, in addresses
`define PC_W             8
`define PC_ENTRY_NORMAL  8'h04
`define PC_ENTRY_SHORT   8'h03
`define PC_PER_INSTR     8'h01
`define PC_PER_SYS       8'h03

// ==========================================================
// Cause reporting positions
`define BREAK_FLAG_POS   33
`define ENTRY_METHOD_POS 12
`define STATUS_W         13

// ==========================================================
// Synchroniser
`define SYNC_STAGES      2

`endif

// *** rtl/debug_entry_pkg.sv ***
// Types shared by the debug entry logic.
// Assumes the constants header is available on the include path.
package debug_entry_pkg;
  `include "debug_entry_cfg.svh"

  typedef enum logic [1:0] {
    MODE_PROGRAM,
    MODE_IRQ,
    MODE_ABORT,
    MODE_EXCEPTION
  } core_mode_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT_ABORT,
    ST_DEBUG,
    ST_SYS_ACCESS,
    ST_SYS_ABORT
  } dbg_state_e;

  typedef logic [`PC_W-1:0] pc_adv_t;
endpackage : debug_entry_pkg

// *** rtl/pc_advance.sv ***
// Accumulator of program counter advance while debugging.
// Assumes load and add come from logic on the same clock.
`timescale 1ns/10ps
module pc_advance #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_value,
  input  wire logic         i_add,
  input  wire logic [W-1:0] i_add_value,
  // Result
  output logic      [W-1:0] o_count
);

  // ==========================================================
  // Accumulate
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_count <= '0;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_add) begin
      o_count <= W'(o_count + i_add_value);
    end
  end

endmodule : pc_advance

// *** rtl/debug_entry_return_address.sv ***
// Debug entry control: mode on entry, cause report and PC advance.
// Assumes core event strobes are on i_core_clk; the test clock and
// the scan-side levels and the external request arrive asynchronously.
`timescale 1ns/10ps
`include "debug_entry_cfg.svh"
module debug_entry_return_address
  import debug_entry_pkg::*;
#(
  parameter int PW = `PC_W
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rstn,
  // Core events, same clock
  input  wire logic          i_breakpoint_hit,
  input  wire logic          i_watchpoint_hit,
  input  wire logic          i_prefetch_abort,
  input  wire logic          i_data_abort,
  input  wire logic          i_other_exception,
  input  wire logic          i_irq_pending,
  input  wire logic          i_abort_vector_fetched,
  input  wire logic          i_sys_access_start,
  input  wire logic          i_sys_access_done,
  input  wire logic          i_sys_access_abort,
  // Asynchronous inputs
  input  wire logic          i_external_debug_request,
  input  wire logic          i_tck,
  input  wire logic          i_scan_instr,
  input  wire logic          i_scan_restart,
  // Status
  output logic               o_debug_state,
  output core_mode_e         o_core_mode,
  output logic               o_interrupt_disable,
  output logic               o_irq_remembered,
  output logic               o_abort_remembered,
  output logic               o_take_prefetch_abort,
  output logic               o_break_flag_bit,
  output logic               o_entry_method_bit,
  output logic [`STATUS_W-1:0] o_debug_status,
  output logic [PW-1:0]      o_pc_advance
);

  // ==========================================================
  // Synchronisers for asynchronous inputs
  localparam int NS = 4;
  logic [NS-1:0] async_in;
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  logic          tck_prev;

  assign async_in = {i_scan_restart, i_scan_instr, i_tck, i_external_debug_request};

  generate
    for (genvar g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= async_in[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= sync_b[1];
    end
  end

  logic ext_req;
  logic tck_rise;
  logic scan_instr_step;
  logic scan_restart_step;

  assign ext_req           = sync_b[0];
  assign tck_rise          = sync_b[1] && !tck_prev;
  assign scan_instr_step   = tck_rise && sync_b[2];
  assign scan_restart_step = tck_rise && sync_b[3];

  // ==========================================================
  // Entry decode
  function automatic logic exc_with_wpt(input logic irq, input logic exc);
    exc_with_wpt = irq || exc;
  endfunction

  dbg_state_e state;
  dbg_state_e next_state;
  logic       bkpt_entry;
  logic       wpt_abort;
  logic       wpt_exc;
  logic       req_entry;

  // Prefetch abort wins; the breakpoint is dropped
  assign bkpt_entry = i_breakpoint_hit && !i_prefetch_abort;
  assign wpt_abort  = i_watchpoint_hit && i_data_abort;
  assign wpt_exc    = i_watchpoint_hit && !i_data_abort
                      && exc_with_wpt(i_irq_pending, i_other_exception);
  assign req_entry  = ext_req && !bkpt_entry && !i_watchpoint_hit;

  // ==========================================================
  // State machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (wpt_abort) begin
          next_state = ST_WAIT_ABORT;
        end else if (bkpt_entry || i_watchpoint_hit || req_entry) begin
          next_state = ST_DEBUG;
        end
      end
      ST_WAIT_ABORT: begin
        if (i_abort_vector_fetched) begin
          next_state = ST_DEBUG;
        end
      end
      ST_DEBUG: begin
        if (scan_restart_step) begin
          next_state = ST_RUN;
        end else if (i_sys_access_start) begin
          next_state = ST_SYS_ACCESS;
        end
      end
      ST_SYS_ACCESS: begin
        if (i_sys_access_abort) begin
          next_state = ST_SYS_ABORT;
        end else if (i_sys_access_done) begin
          next_state = ST_DEBUG;
        end
      end
      ST_SYS_ABORT: begin
        next_state = ST_DEBUG;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  logic entering;
  assign entering = (next_state == ST_DEBUG)
                    && (state == ST_RUN || state == ST_WAIT_ABORT);

  // ==========================================================
  // Processor mode on entry
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_mode <= MODE_PROGRAM;
    end else if (state == ST_RUN && wpt_abort) begin
      o_core_mode <= MODE_ABORT;
    end else if (state == ST_RUN && wpt_exc) begin
      o_core_mode <= i_irq_pending ? MODE_IRQ : MODE_EXCEPTION;
    end else if (state == ST_RUN && entering && i_irq_pending) begin
      o_core_mode <= MODE_IRQ;
    end else if (state == ST_SYS_ACCESS && i_sys_access_abort) begin
      o_core_mode <= MODE_ABORT;
    end else if (state == ST_DEBUG && scan_restart_step) begin
      o_core_mode <= MODE_PROGRAM;
    end
  end

  // ==========================================================
  // Remembered exceptions
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_remembered <= 1'b0;
    end else if (state == ST_RUN && entering && i_irq_pending) begin
      o_irq_remembered <= 1'b1;
    end else if (state == ST_DEBUG && scan_restart_step) begin
      o_irq_remembered <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_abort_remembered <= 1'b0;
    end else if (state == ST_RUN && wpt_abort) begin
      o_abort_remembered <= 1'b1;
    end else if (state == ST_DEBUG && scan_restart_step) begin
      o_abort_remembered <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_take_prefetch_abort <= 1'b0;
    end else begin
      o_take_prefetch_abort <= state == ST_RUN && i_prefetch_abort;
    end
  end

  // ==========================================================
  // Debug state and interrupt disable
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_debug_state       <= 1'b0;
      o_interrupt_disable <= 1'b0;
    end else if (entering) begin
      o_debug_state       <= 1'b1;
      o_interrupt_disable <= 1'b1;
    end else if (next_state == ST_RUN) begin
      o_debug_state       <= 1'b0;
      o_interrupt_disable <= 1'b0;
    end
  end

  // ==========================================================
  // Cause report
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_break_flag_bit   <= 1'b0;
      o_entry_method_bit <= 1'b0;
    end else if (state == ST_RUN && entering) begin
      o_break_flag_bit   <= i_watchpoint_hit;
      o_entry_method_bit <= req_entry;
    end else if (state == ST_WAIT_ABORT && entering) begin
      o_break_flag_bit   <= 1'b1;
      o_entry_method_bit <= 1'b0;
    end else if (state == ST_SYS_ACCESS && i_sys_access_done) begin
      o_break_flag_bit   <= 1'b1;
    end
  end

  always_comb begin
    o_debug_status = '0;
    o_debug_status[`ENTRY_METHOD_POS] = o_entry_method_bit;
    o_debug_status[0] = o_debug_state;
  end

  // ==========================================================
  // Program counter advance
  logic    pc_load;
  pc_adv_t pc_load_value;
  logic    pc_add;
  pc_adv_t pc_add_value;

  assign pc_load = entering;

  always_comb begin
    if (state == ST_WAIT_ABORT || (state == ST_RUN && (wpt_exc || req_entry))) begin
      pc_load_value = `PC_ENTRY_SHORT;
    end else begin
      pc_load_value = `PC_ENTRY_NORMAL;
    end
  end

  always_comb begin
    pc_add       = 1'b0;
    pc_add_value = `PC_PER_INSTR;
    if (state == ST_SYS_ACCESS && (i_sys_access_done || i_sys_access_abort)) begin
      pc_add       = 1'b1;
      pc_add_value = `PC_PER_SYS;
    end else if (state == ST_DEBUG && scan_instr_step) begin
      pc_add       = 1'b1;
      pc_add_value = `PC_PER_INSTR;
    end
  end

  pc_advance #(
    .W (PW)
  ) u_pc_advance (
    .i_core_clk   (i_core_clk),
    .i_rstn       (i_rstn),
    .i_load       (pc_load),
    .i_load_value (PW'(pc_load_value)),
    .i_add        (pc_add),
    .i_add_value  (PW'(pc_add_value)),
    .o_count      (o_pc_advance)
  );

endmodule : debug_entry_return_address

// *** verif/debug_entry_return_address_assertions.sv ***
// Checks on the debug entry block ports.
// Assumes debug_entry_pkg is compiled first.
`timescale 1ns/10ps
module debug_entry_return_address_chk
  import debug_entry_pkg::*;
#(
  parameter int PW = 8
) (
  // Clock, reset, events
  input wire logic          i_core_clk,
  input wire logic          i_rstn,
  input wire logic          i_breakpoint_hit,
  input wire logic          i_watchpoint_hit,
  input wire logic          i_prefetch_abort,
  input wire logic          i_data_abort,
  input wire logic          i_other_exception,
  input wire logic          i_irq_pending,
  input wire logic          i_abort_vector_fetched,
  input wire logic          i_sys_access_start,
  input wire logic          i_sys_access_done,
  input wire logic          i_sys_access_abort,
  // Status
  input wire logic          o_debug_state,
  input wire core_mode_e    o_core_mode,
  input wire logic          o_interrupt_disable,
  input wire logic          o_abort_remembered,
  input wire logic          o_take_prefetch_abort,
  input wire logic          o_break_flag_bit,
  input wire logic          o_entry_method_bit,
  input wire logic [12:0]   o_debug_status,
  input wire logic [PW-1:0] o_pc_advance
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================
  // Helpers
  logic run;
  logic in_sys;
  assign run = !o_debug_state && o_core_mode == MODE_PROGRAM;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) in_sys <= 1'b0;
    else if (i_sys_access_done || i_sys_access_abort) in_sys <= 1'b0;
    else if (o_debug_state && i_sys_access_start) in_sys <= 1'b1;
  end
  // ==========================================
  // Properties
  chk_bkpt_entry:
  assert property (run && i_breakpoint_hit && !i_prefetch_abort && !i_watchpoint_hit |=>
    o_debug_state && o_pc_advance == 8'h04 && !o_break_flag_bit && !o_entry_method_bit)
    else $error("breakpoint entry wrong");
  chk_wpt_entry:
  assert property (run && i_watchpoint_hit && !i_data_abort && !i_other_exception
    && !i_irq_pending |=> o_pc_advance == 8'h04 && o_break_flag_bit && !o_entry_method_bit)
    else $error("watchpoint entry wrong");
  chk_exc_entry:
  assert property (run && i_watchpoint_hit && i_other_exception && !i_data_abort
    && !i_irq_pending |=>
    o_debug_state && o_core_mode == MODE_EXCEPTION && o_pc_advance == 8'h03)
    else $error("exception entry wrong");
  chk_abort_wait:
  assert property (run && i_watchpoint_hit && i_data_abort |=>
    (!o_debug_state && o_core_mode == MODE_ABORT)[*4]) else $error("abort not held off");
  chk_abort_entry:
  assert property (!o_debug_state && o_core_mode == MODE_ABORT && i_abort_vector_fetched
    |=> o_debug_state && o_abort_remembered && o_pc_advance == 8'h03)
    else $error("abort entry wrong");
  chk_irq_masked:
  assert property (o_debug_state |-> o_interrupt_disable) else $error("irq not masked");
  chk_sys_step:
  assert property (in_sys && i_sys_access_done && !i_sys_access_abort |=>
    o_pc_advance == $past(o_pc_advance) + 8'h03 && o_break_flag_bit)
    else $error("system step wrong");
  chk_sys_abort:
  assert property (in_sys && i_sys_access_abort |=> o_core_mode == MODE_ABORT ##1
    o_debug_state) else $error("system abort wrong");
  chk_pf_priority:
  assert property (run && i_breakpoint_hit && i_prefetch_abort && !i_watchpoint_hit |=>
    o_take_prefetch_abort && !o_debug_state) else $error("prefetch priority wrong");
  chk_status_word:
  assert property (o_debug_status == {o_entry_method_bit, 11'h000, o_debug_state})
    else $error("status word wrong");
  cover property (run && i_breakpoint_hit);
  cover property (in_sys && i_sys_access_abort);
  cover property ($rose(o_debug_state) && o_entry_method_bit);
endmodule : debug_entry_return_address_chk

bind debug_entry_return_address debug_entry_return_address_chk #(.PW(PW)) u_chk (
  .i_core_clk, .i_rstn, .i_breakpoint_hit, .i_watchpoint_hit, .i_prefetch_abort,
  .i_data_abort, .i_other_exception, .i_irq_pending, .i_abort_vector_fetched,
  .i_sys_access_start, .i_sys_access_done, .i_sys_access_abort, .o_debug_state,
  .o_core_mode, .o_interrupt_disable, .o_abort_remembered, .o_take_prefetch_abort,
  .o_break_flag_bit, .o_entry_method_bit, .o_debug_status, .o_pc_advance
);

// *** verif/debugger_model.sv ***
// Debugger model: clocks the test port, scans steps.
// Assumes the block syncs these levels to its own clock.
`timescale 1ns/10ps
module debugger_model (
  // Test port
  output logic o_tck,
  output logic o_scan_instr,
  output logic o_scan_restart
);
  initial begin
    o_tck = 1'b0;
    o_scan_instr = 1'b0;
    o_scan_restart = 1'b0;
  end
  // One 64 ns frame, clock idle low outside it
  task automatic pulse(input logic instr, input logic rst);
    o_scan_instr = instr;
    o_scan_restart = rst;
    #13 o_tck = 1'b1;
    #32 o_tck = 1'b0;
    #10 o_scan_instr = 1'b0;
    o_scan_restart = 1'b0;
    #9;
  endtask : pulse
  // Debug-speed steps, last one the return branch
  task automatic steps(input int n);
    for (int i = 0; i < n; i++) pulse(1'b1, 1'b0);
  endtask : steps
endmodule : debugger_model

// *** verif/tb_debug_entry_return_address.sv ***
// Bench for the debug entry block.
// Assumes the checker is bound and the debugger model is present.
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_debug_entry_return_address
  import debug_entry_pkg::*;
;
  localparam logic [9:0] BK = 10'h200, WP = 10'h100, PA = 10'h080, DA = 10'h040;
  localparam logic [9:0] EX = 10'h020, IQ = 10'h010, VF = 10'h008, SS = 10'h004;
  localparam logic [9:0] SD = 10'h002, SA = 10'h001;
  logic       i_core_clk, i_rstn, xrq;
  logic [9:0] evt;
  wire        tck, s_in, s_rs;
  logic       o_debug_state, o_interrupt_disable, o_irq_remembered, o_abort_remembered;
  logic       o_take_prefetch_abort, o_break_flag_bit, o_entry_method_bit;
  core_mode_e o_core_mode;
  logic [12:0] o_debug_status;
  logic [7:0] o_pc_advance;
  int         n_errors = 0, samples_checked = 0, cycles = 0;

  debug_entry_return_address u_dut (
    .i_core_clk, .i_rstn,
    .i_breakpoint_hit (evt[9]), .i_watchpoint_hit (evt[8]),
    .i_prefetch_abort (evt[7]), .i_data_abort (evt[6]),
    .i_other_exception (evt[5]), .i_irq_pending (evt[4]),
    .i_abort_vector_fetched (evt[3]), .i_sys_access_start (evt[2]),
    .i_sys_access_done (evt[1]), .i_sys_access_abort (evt[0]),
    .i_external_debug_request (xrq), .i_tck (tck),
    .i_scan_instr (s_in), .i_scan_restart (s_rs),
    .o_debug_state, .o_core_mode, .o_interrupt_disable, .o_irq_remembered,
    .o_abort_remembered, .o_take_prefetch_abort, .o_break_flag_bit,
    .o_entry_method_bit, .o_debug_status, .o_pc_advance
  );
  debugger_model u_dbg (.o_tck (tck), .o_scan_instr (s_in), .o_scan_restart (s_rs));

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic ev(input logic [9:0] v);
    @(posedge i_core_clk);
    evt <= v;
    @(posedge i_core_clk);
    evt <= 10'h000;
    @(negedge i_core_clk);
  endtask : ev
  task automatic chk(input logic ds, input core_mode_e m, input logic bf, input logic mb,
                     input logic [7:0] pc);
    `CHECK("debug_state", ds, o_debug_state)
    `CHECK("irq_disable", ds, o_interrupt_disable)
    `CHECK("core_mode", m, o_core_mode)
    if (!mb) `CHECK("break_flag", bf, o_break_flag_bit)
    `CHECK("status", {mb, 11'h000, ds}, o_debug_status)
    `CHECK("pc_advance", pc, o_pc_advance)
  endtask : chk
  task automatic leave(input int n, input int s, input logic [7:0] base);
    u_dbg.steps(n);
    @(negedge i_core_clk);
    `CHECK("return_span", base + 8'(n) + 8'(3 * s), o_pc_advance)
    u_dbg.pulse(1'b0, 1'b1);
    @(negedge i_core_clk);
    `CHECK("exit", 4'h0, {o_debug_state, o_core_mode, o_irq_remembered})
    `CHECK("exit_abort", 1'b0, o_abort_remembered)
  endtask : leave
  // ==========================================
  // Scenarios
  task automatic t_prefetch;
    ev(BK | PA);
    `CHECK("pf_taken", 2'b10, {o_take_prefetch_abort, o_debug_state})
    u_dbg.pulse(1'b1, 1'b0);
    @(negedge i_core_clk);
    `CHECK("pf_no_entry", 9'h000, {o_debug_state, o_pc_advance})
  endtask : t_prefetch
  task automatic t_breakpoint;
    ev(BK);
    chk(1'b1, MODE_PROGRAM, 1'b0, 1'b0, 8'h04);
    leave(3, 0, 8'h04);
    ev(BK | IQ);
    chk(1'b1, MODE_IRQ, 1'b0, 1'b0, 8'h04);
    `CHECK("irq_kept", 1'b1, o_irq_remembered)
    leave(3, 0, 8'h04);
  endtask : t_breakpoint
  task automatic t_watchpoint_sys;
    ev(WP);
    chk(1'b1, MODE_PROGRAM, 1'b1, 1'b0, 8'h04);
    ev(SS);
    ev(SD);
    chk(1'b1, MODE_PROGRAM, 1'b1, 1'b0, 8'h07);
    ev(SS);
    ev(SA);
    `CHECK("sys_abort", MODE_ABORT, o_core_mode)
    @(negedge i_core_clk);
    `CHECK("sys_back", 9'h10a, {o_debug_state, o_pc_advance})
    leave(3, 2, 8'h04);
  endtask : t_watchpoint_sys
  task automatic t_wpt_exception;
    ev(WP | EX);
    chk(1'b1, MODE_EXCEPTION, 1'b1, 1'b0, 8'h03);
    leave(3, 0, 8'h03);
    ev(WP | IQ);
    chk(1'b1, MODE_IRQ, 1'b1, 1'b0, 8'h03);
    leave(3, 0, 8'h03);
  endtask : t_wpt_exception
  task automatic t_wpt_abort;
    ev(WP | DA);
    repeat (4) begin
      `CHECK("held_off", 2'b10, {o_core_mode == MODE_ABORT, o_debug_state})
      @(negedge i_core_clk);
    end
    ev(VF);
    chk(1'b1, MODE_ABORT, 1'b1, 1'b0, 8'h03);
    `CHECK("abort_kept", 1'b1, o_abort_remembered)
    leave(3, 0, 8'h03);
  endtask : t_wpt_abort
  task automatic t_ext_request;
    @(posedge i_core_clk);
    xrq <= 1'b1;
    for (int k = 0; k < 20 && o_debug_state !== 1'b1; k++) @(negedge i_core_clk);
    @(posedge i_core_clk);
    xrq <= 1'b0;
    @(negedge i_core_clk);
    chk(1'b1, MODE_PROGRAM, 1'b0, 1'b1, 8'h03);
    leave(3, 0, 8'h03);
  endtask : t_ext_request
  initial begin
    i_rstn = 1'b0;
    xrq = 1'b0;
    evt = 10'h000;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(negedge i_core_clk);
    t_prefetch();
    t_breakpoint();
    t_watchpoint_sys();
    t_wpt_exception();
    t_wpt_abort();
    t_ext_request();
    summarize();
  end
endmodule : tb_debug_entry_return_address
